// ---- hdl/egf_follower.sv ----
/*
 Electronic gearing follower: eight follower axes geared to one selectable
 master, with forward/reverse trippoints and an APB register file.
 Assumes servoTick pulses once per servo update on clk, axis positions are
 synchronous to clk, and limit switch levels arrive asynchronously.
*/
// The APB register port and the register offsets were left to the implementer.
// Function
// RQ1 - Up to eight follower axes all slave to one shared master source
// RQ2 - Followers track master motion proportionally in both directions
// RQ3 - Each axis holds its own ratio; rewriting it never stops the axis
// RQ4 - One master selection at a time; a new one replaces the old
// RQ5 - Signed ratio up to 127.9999 in steps of 0.0001
// RQ6 - Ratio zero turns gearing off on that axis only
// RQ7 - An active limit switch turns gearing off on that axis
// RQ8 - Plain axis master uses its measured encoder position
// RQ9 - Master is main encoder, commanded position, aux encoder or vector path
// RQ10 - Commanded position of a driven axis may serve as master
// RQ11 - Vector master follows commanded path distance of coordinated axes
// RQ12 - A profiled move adds on top of the geared command
// RQ13 - Reverse trippoint holds until axis passes position going reverse
// RQ14 - Forward trippoint holds until axis passes position going forward
// RQ15 - Per update: delta times ratio, keep fraction, add integer to command
`timescale 1ns/1ns
`include "egf_regs.svh"

module egf_follower (
   // Clock, reset, enable and servo update
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic servoTick,
   // Register bus
   input wire egf_pkg::egf_apb_req_t apbReq,
   output egf_pkg::egf_apb_rsp_t apbRsp,
   // Axis positions and limit switches
   input wire egf_pkg::egf_axes_in_t axIn,
   input wire logic [7:0] limitIn,
   // Follower commands and status
   output egf_pkg::egf_pos_arr_t followCmd,
   output logic [7:0] gearActive,
   output logic tripHold
);
   import egf_pkg::*;

   egf_state_t st_ff;
   egf_state_t nxt_st;
   egf_pos_t masterNow;
   egf_pos_t delta;
   egf_pos_t tripNow;
   egf_step_t stp;
   logic apbTake;
   logic [7:0] addr;

   // Fraction kept as remainder so no counts are lost over many updates
   function automatic egf_step_t gear_step(egf_pos_t d, egf_ratio_t r, egf_rem_t rm);
      logic signed [63:0] acc;
      logic signed [63:0] q;
      egf_step_t res;
      acc = 64'(d) * 64'(r) + 64'(rm);
      q = acc / `EGF_RATIO_SCALE;
      res.step = 32'(q);
      res.rem = 15'(acc - q * `EGF_RATIO_SCALE);
      return res;
   endfunction

   // Out-of-range writes saturate instead of wrapping to a wrong sign
   function automatic egf_ratio_t ratio_sat(logic signed [31:0] w);
      if (w > 32'(`EGF_RATIO_MAX)) begin
         return `EGF_RATIO_MAX;
      end else if (w < -32'(`EGF_RATIO_MAX)) begin
         return -`EGF_RATIO_MAX;
      end
      return 22'(w);
   endfunction

   assign addr = apbReq.paddr;
   assign apbTake = apbReq.psel && apbReq.penable && st_ff.rdy && ce;

   always_comb begin
      nxt_st = st_ff;
      stp = '0;
      // Master source mux
      unique case (st_ff.srcType)
         SRC_MAIN: masterNow = axIn.mainPos[st_ff.srcAxis]; // RQ8
         SRC_CMD: masterNow = axIn.cmdPos[st_ff.srcAxis]; // RQ10
         SRC_AUX: masterNow = axIn.auxPos[st_ff.srcAxis]; // RQ9
         SRC_VECTOR: masterNow = axIn.vecDist; // RQ11
      endcase
      delta = masterNow - st_ff.prevMaster; // RQ2
      tripNow = axIn.mainPos[st_ff.tripAxis];

      // Limit switches: three stages, change taken once stages two and three agree
      nxt_st.lim1 = limitIn;
      nxt_st.lim2 = st_ff.lim1;
      nxt_st.lim3 = st_ff.lim2;
      nxt_st.limFilt = (st_ff.lim2 & st_ff.lim3) |
                       (st_ff.limFilt & (st_ff.lim2 | st_ff.lim3));

      // Servo update; first update after a new master only rebases
      if (servoTick) begin
         nxt_st.prevMaster = masterNow;
         nxt_st.resync = 1'b0;
         if (!st_ff.resync) begin
            for (int i = 0; i < 8; i++) begin
               if (st_ff.gearEn[i]) begin // RQ1
                  stp = gear_step(delta, st_ff.ratio[i], st_ff.rem[i]); // RQ15
                  nxt_st.gearPos[i] = st_ff.gearPos[i] + stp.step; // RQ15
                  nxt_st.rem[i] = stp.rem;
               end
            end
         end
      end

      // Geared command plus independent profiled move
      for (int i = 0; i < 8; i++) begin
         nxt_st.followCmd[i] = st_ff.gearPos[i] + axIn.profCmd[i]; // RQ12
      end

      // Trippoint
      unique case (st_ff.tripState)
         TRIP_IDLE: begin
         end
         TRIP_FWD: begin
            if (tripNow > st_ff.tripPos) begin
               nxt_st.tripState = TRIP_IDLE; // RQ14
            end
         end
         TRIP_REV: begin
            if (tripNow < st_ff.tripPos) begin
               nxt_st.tripState = TRIP_IDLE; // RQ13
            end
         end
         default: nxt_st.tripState = TRIP_IDLE;
      endcase

      // APB setup: read data and error captured ahead of the access phase
      if (apbReq.psel && !st_ff.rdy) begin
         nxt_st.rdy = 1'b1;
         nxt_st.prdata = '0;
         nxt_st.pslverr = 1'b0;
         if (addr == `EGF_MSEL_OFS) begin
            nxt_st.prdata[`EGF_MSEL_TYPE_LSB +: 2] = st_ff.srcType;
            nxt_st.prdata[`EGF_MSEL_AXIS_LSB +: 3] = st_ff.srcAxis;
         end else if (addr == `EGF_TRIPCTL_OFS) begin
            nxt_st.prdata[`EGF_TRIP_ARM_BIT] = st_ff.tripState != TRIP_IDLE;
            nxt_st.prdata[`EGF_TRIP_REV_BIT] = st_ff.tripState == TRIP_REV;
            nxt_st.prdata[`EGF_TRIP_AXIS_LSB +: 3] = st_ff.tripAxis;
         end else if (addr == `EGF_TRIPPOS_OFS) begin
            nxt_st.prdata = st_ff.tripPos;
         end else if (addr == `EGF_STATUS_OFS) begin
            nxt_st.prdata[7:0] = st_ff.gearEn;
            nxt_st.prdata[`EGF_STAT_HOLD_BIT] = st_ff.tripState != TRIP_IDLE;
            nxt_st.pslverr = apbReq.pwrite;
         end else if ((addr & `EGF_BANK_MASK) == `EGF_RATIO_BASE && addr[1:0] == 2'h0) begin
            nxt_st.prdata = 32'(st_ff.ratio[addr[4:2]]);
         end else if ((addr & `EGF_BANK_MASK) == `EGF_CMD_BASE && addr[1:0] == 2'h0) begin
            nxt_st.prdata = st_ff.followCmd[addr[4:2]];
            nxt_st.pslverr = apbReq.pwrite;
         end else begin
            nxt_st.pslverr = 1'b1;
         end
      end

      // APB access: writes take effect at the answering edge
      if (apbTake) begin
         nxt_st.rdy = 1'b0;
         if (apbReq.pwrite && !st_ff.pslverr) begin
            if (addr == `EGF_MSEL_OFS) begin
               nxt_st.srcType = egf_src_t'(apbReq.pwdata[`EGF_MSEL_TYPE_LSB +: 2]); // RQ4
               nxt_st.srcAxis = apbReq.pwdata[`EGF_MSEL_AXIS_LSB +: 3]; // RQ4
               nxt_st.resync = 1'b1; // RQ4
            end else if (addr == `EGF_TRIPCTL_OFS) begin
               nxt_st.tripAxis = apbReq.pwdata[`EGF_TRIP_AXIS_LSB +: 3];
               if (!apbReq.pwdata[`EGF_TRIP_ARM_BIT]) begin
                  nxt_st.tripState = TRIP_IDLE;
               end else if (apbReq.pwdata[`EGF_TRIP_REV_BIT]) begin
                  nxt_st.tripState = TRIP_REV; // RQ13
               end else begin
                  nxt_st.tripState = TRIP_FWD; // RQ14
               end
            end else if (addr == `EGF_TRIPPOS_OFS) begin
               nxt_st.tripPos = apbReq.pwdata;
            end else if ((addr & `EGF_BANK_MASK) == `EGF_RATIO_BASE) begin
               // Gear position and remainder are kept so the axis never stops
               nxt_st.ratio[addr[4:2]] = ratio_sat(apbReq.pwdata); // RQ3 RQ5
               nxt_st.gearEn[addr[4:2]] = apbReq.pwdata != 32'h0; // RQ6
            end
         end
      end

      // Limit wins over a ratio write in the same cycle
      nxt_st.gearEn = nxt_st.gearEn & ~nxt_st.limFilt; // RQ7
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= `EGF_STATE_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign apbRsp.pready = apbReq.psel && apbReq.penable && st_ff.rdy && ce;
   assign apbRsp.prdata = st_ff.prdata;
   assign apbRsp.pslverr = st_ff.pslverr;
   assign followCmd = st_ff.followCmd;
   assign gearActive = st_ff.gearEn;
   assign tripHold = st_ff.tripState != TRIP_IDLE;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_ratio_write;
      apbTake && apbReq.pwrite && !st_ff.pslverr &&
      (addr & `EGF_BANK_MASK) == `EGF_RATIO_BASE;
   endsequence

   sequence s_msel_write;
      apbTake && apbReq.pwrite && !st_ff.pslverr && addr == `EGF_MSEL_OFS;
   endsequence

   property p_ratio_zero_off;
      s_ratio_write ##0 (apbReq.pwdata == 32'h0) |=>
         !gearActive[$past(addr[4:2])];
   endproperty
   a_ratio_zero_off: assert property (p_ratio_zero_off) else $error("zero ratio left gearing on"); // RQ6

   property p_ratio_live;
      s_ratio_write ##0 (apbReq.pwdata == 32'(`EGF_RATIO_UNITY)) ##0
         !nxt_st.limFilt[addr[4:2]] |=>
         st_ff.ratio[$past(addr[4:2])] == `EGF_RATIO_UNITY &&
         gearActive[$past(addr[4:2])];
   endproperty
   a_ratio_live: assert property (p_ratio_live) else $error("ratio write not applied"); // RQ3

   property p_ratio_sat;
      s_ratio_write ##0 ($signed(apbReq.pwdata) > 32'sd2000000) |=>
         st_ff.ratio[$past(addr[4:2])] == `EGF_RATIO_MAX;
   endproperty
   a_ratio_sat: assert property (p_ratio_sat) else $error("ratio not limited"); // RQ5

   property p_limit_off;
      (st_ff.limFilt & st_ff.gearEn) == 8'h0;
   endproperty
   a_limit_off: assert property (p_limit_off) else $error("gearing on with limit active"); // RQ7

   property p_master_swap;
      s_msel_write |=> st_ff.resync &&
         st_ff.srcAxis == $past(apbReq.pwdata[`EGF_MSEL_AXIS_LSB +: 3]);
   endproperty
   a_master_swap: assert property (p_master_swap) else $error("master select not applied"); // RQ4

   sequence s_rebase_tick;
      ce && servoTick && st_ff.resync && !(apbTake && apbReq.pwrite && addr == `EGF_MSEL_OFS);
   endsequence

   // First update after a new master moves nobody, so the swap never jumps
   property p_rebase_only;
      s_rebase_tick |=> !st_ff.resync && st_ff.gearPos == $past(st_ff.gearPos) &&
         st_ff.prevMaster == $past(masterNow);
   endproperty
   a_rebase_only: assert property (p_rebase_only) else $error("rebase moved a follower"); // RQ4

   property p_unity_track;
      (ce && servoTick && !st_ff.resync && st_ff.gearEn[2] &&
       st_ff.ratio[2] == `EGF_RATIO_UNITY && st_ff.rem[2] == 15'sh0) |=>
         st_ff.gearPos[2] == $past(st_ff.gearPos[2]) + $past(delta);
   endproperty
   a_unity_track: assert property (p_unity_track) else $error("follower missed master delta"); // RQ2

   property p_sum_out;
      ce |=> followCmd[1] == $past(st_ff.gearPos[1]) + $past(axIn.profCmd[1]);
   endproperty
   a_sum_out: assert property (p_sum_out) else $error("profiled move not added"); // RQ12

   property p_trip_fwd;
      (ce && st_ff.tripState == TRIP_FWD && tripNow > st_ff.tripPos && !apbTake) |=>
         !tripHold;
   endproperty
   a_trip_fwd: assert property (p_trip_fwd) else $error("forward trippoint not released"); // RQ14

   property p_trip_rev;
      (ce && st_ff.tripState == TRIP_REV && tripNow >= st_ff.tripPos && !apbTake) |=>
         tripHold;
   endproperty
   a_trip_rev: assert property (p_trip_rev) else $error("reverse trippoint released early"); // RQ13

   property p_cmd_master;
      ce && servoTick && st_ff.srcType == SRC_CMD |=>
         st_ff.prevMaster == $past(axIn.cmdPos[st_ff.srcAxis]);
   endproperty
   a_cmd_master: assert property (p_cmd_master) else $error("commanded master not used"); // RQ10

   property p_vec_master;
      ce && servoTick && st_ff.srcType == SRC_VECTOR |=>
         st_ff.prevMaster == $past(axIn.vecDist);
   endproperty
   a_vec_master: assert property (p_vec_master) else $error("path master not used"); // RQ11

   property p_main_master;
      ce && servoTick && st_ff.srcType == SRC_MAIN |=>
         st_ff.prevMaster == $past(axIn.mainPos[st_ff.srcAxis]);
   endproperty
   a_main_master: assert property (p_main_master) else $error("measured master not used"); // RQ8

endmodule

// ---- hdl/egf_regs.svh ----
/*
 Register offsets, field positions, reset values and arithmetic constants
 of the electronic gearing follower. Assumes byte addresses on an 8-bit APB
 address with one aligned 32-bit word per register.
*/
`ifndef EGF_REGS_SVH
`define EGF_REGS_SVH

// Register byte offsets
`define EGF_MSEL_OFS 8'h00
`define EGF_TRIPCTL_OFS 8'h04
`define EGF_TRIPPOS_OFS 8'h08
`define EGF_STATUS_OFS 8'h0c
`define EGF_RATIO_BASE 8'h20
`define EGF_CMD_BASE 8'h40
`define EGF_BANK_MASK 8'he0

// Field positions
`define EGF_MSEL_TYPE_LSB 0
`define EGF_MSEL_AXIS_LSB 4
`define EGF_TRIP_ARM_BIT 0
`define EGF_TRIP_REV_BIT 1
`define EGF_TRIP_AXIS_LSB 4
`define EGF_STAT_HOLD_BIT 8

// Ratio arithmetic: units of 0.0001
`define EGF_RATIO_SCALE 64'sd10000
`define EGF_RATIO_MAX 22'sd1279999
`define EGF_RATIO_UNITY 22'sd10000

// Reset value of the whole state
`define EGF_STATE_RST '0

`endif

// ---- hdl/egf_pkg.sv ----
/*
 Types of the electronic gearing follower: positions, ratios, modes,
 bus and axis carriers, and the module state. Assumes egf_regs.svh beside it.
*/
package egf_pkg;

   typedef logic signed [31:0] egf_pos_t;
   typedef egf_pos_t [7:0] egf_pos_arr_t;
   typedef logic signed [21:0] egf_ratio_t;
   typedef logic signed [14:0] egf_rem_t;

   typedef enum logic [1:0] {SRC_MAIN, SRC_CMD, SRC_AUX, SRC_VECTOR} egf_src_t;
   typedef enum logic [1:0] {TRIP_IDLE, TRIP_FWD, TRIP_REV} egf_trip_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } egf_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } egf_apb_rsp_t;

   typedef struct packed {
      egf_pos_arr_t mainPos;
      egf_pos_arr_t auxPos;
      egf_pos_arr_t cmdPos;
      egf_pos_arr_t profCmd;
      egf_pos_t vecDist;
   } egf_axes_in_t;

   typedef struct packed {
      egf_pos_t step;
      egf_rem_t rem;
   } egf_step_t;

   typedef struct packed {
      egf_src_t srcType;
      logic [2:0] srcAxis;
      logic resync;
      egf_ratio_t [7:0] ratio;
      logic [7:0] gearEn;
      egf_pos_t prevMaster;
      egf_rem_t [7:0] rem;
      egf_pos_arr_t gearPos;
      egf_pos_arr_t followCmd;
      egf_trip_t tripState;
      logic [2:0] tripAxis;
      egf_pos_t tripPos;
      logic [7:0] lim1;
      logic [7:0] lim2;
      logic [7:0] lim3;
      logic [7:0] limFilt;
      logic rdy;
      logic [31:0] prdata;
      logic pslverr;
   } egf_state_t;

endpackage

// ---- verif/egf_axis_model.sv ----
/*
 Partner model: master and follower axis positions fed to the gearing block.
 Assumes the bench pulses moveEn for one cycle per master move.
*/
`timescale 1ns/1ns

module egf_axis_model (
   // Clock, reset and move request
   input wire logic clk,
   input wire logic srst,
   input wire logic moveEn,
   input wire logic [2:0] moveAxis,
   input wire egf_pkg::egf_pos_t moveDelta,
   // Positions to the block
   output egf_pkg::egf_axes_in_t axIn
);
   import egf_pkg::*;
   egf_axes_in_t pos_ff;
   assign axIn = pos_ff;
   // Each source moves at its own multiple, so a wrong source pick shows up
   always_ff @(posedge clk) begin
      if (srst) begin
         pos_ff <= '0;
      end else begin
         if (moveEn) begin
            pos_ff.mainPos[moveAxis] <= pos_ff.mainPos[moveAxis] + moveDelta;
            pos_ff.cmdPos[moveAxis] <= pos_ff.cmdPos[moveAxis] + 2 * moveDelta;
            pos_ff.auxPos[moveAxis] <= pos_ff.auxPos[moveAxis] + 3 * moveDelta;
            pos_ff.vecDist <= pos_ff.vecDist + 4 * moveDelta;
         end
         // Profiled move on follower 1 stays put so the sum is easy to see
         pos_ff.profCmd[1] <= 32'sh7;
      end
   end
endmodule

// ---- verif/tb.sv ----
/*
 Bench for the gearing follower: master sources, ratios, ratio zero, limit,
 refused accesses and trippoints. Assumes egf_axis_model for the positions.
*/
`timescale 1ns/1ns
`include "egf_regs.svh"

module tb;
   import egf_pkg::*;
   typedef struct {int src; longint ratio; int delta;} egf_row_t;
   logic clk, srst, ce, servoTick, moveEn, tripHold, err;
   logic [2:0] moveAxis;
   logic [7:0] limitIn, gearActive;
   logic [31:0] rd;
   egf_pos_t moveDelta;
   egf_apb_req_t apbReq;
   egf_apb_rsp_t apbRsp;
   egf_axes_in_t axIn;
   egf_pos_arr_t followCmd;
   int error_cnt, checked;
   longint expPos[8], remv[8], ratioV[8], mainNow;
   bit gearOn[8];
   egf_row_t rows[6] = '{'{0, 10000, 50}, '{1, -5000, 7}, '{2, 1279999, -3},
      '{3, 3, 1234}, '{0, -1279999, 2}, '{1, 1, -9999}};

   egf_follower egf_follower_inst (.clk(clk), .srst(srst), .ce(ce),
      .servoTick(servoTick), .apbReq(apbReq), .apbRsp(apbRsp), .axIn(axIn),
      .limitIn(limitIn), .followCmd(followCmd), .gearActive(gearActive),
      .tripHold(tripHold));
   egf_axis_model egf_axis_model_inst (.clk(clk), .srst(srst), .moveEn(moveEn),
      .moveAxis(moveAxis), .moveDelta(moveDelta), .axIn(axIn));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic fail(input string m);
      $display("unexpected at %0t: %s", $time, m);
      error_cnt++;
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) fail(m);
   endtask

   task automatic chkBit(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) fail(m);
   endtask

   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int i;
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (apbRsp.pready === 1'b1) break;
      end
      if (i == 20) begin
         fail("no pready");
         print_verdict();
      end else begin
         rd = apbRsp.prdata;
         err = apbRsp.pslverr;
         apbReq <= '0;
      end
   endtask

   task automatic setRatio(input int a, input longint r);
      apb(1'b1, 8'(`EGF_RATIO_BASE + 4 * a), 32'(r));
      ratioV[a] = r;
      gearOn[a] = (r != 0);
   endtask

   // Master move, one servo tick, then followers 1 and 2 compared
   task automatic move(input int d, input int mult, input bit rebase);
      longint acc;
      int a;
      @(posedge clk);
      moveDelta <= d;
      moveEn <= 1'b1;
      @(posedge clk);
      moveEn <= 1'b0;
      servoTick <= 1'b1;
      @(posedge clk);
      servoTick <= 1'b0;
      repeat (3) @(posedge clk);
      mainNow += d;
      for (a = 1; a < 3; a++) begin
         if (gearOn[a] && !rebase) begin
            acc = longint'(d) * mult * ratioV[a] + remv[a];
            expPos[a] += acc / 10000;
            remv[a] = acc % 10000;
         end
         chkWord(followCmd[a], 32'(expPos[a] + (a == 1 ? 7 : 0)), "follow");
      end
   endtask

   initial begin
      srst = 1'b1;
      ce = 1'b1;
      servoTick = 1'b0;
      moveEn = 1'b0;
      moveAxis = 3'd3;
      moveDelta = '0;
      apbReq = '0;
      limitIn = '0;
      error_cnt = 0;
      checked = 0;
      mainNow = 0;
      repeat (20) @(posedge clk);
      chkWord(followCmd[1], 32'h0, "follow at reset");
      chkWord(32'(gearActive), 32'h0, "gear at reset");
      srst <= 1'b0;
      apb(1'b0, `EGF_MSEL_OFS, 32'h0);
      chkWord(rd, 32'h0, "select at reset");
      $display("test reset done");
      setRatio(2, 10000);
      // Every source type, each ratio applied on the fly
      foreach (rows[i]) begin
         apb(1'b1, `EGF_MSEL_OFS, 32'(rows[i].src) | 32'h30);
         move(11, 1, 1'b1);
         setRatio(1, rows[i].ratio);
         move(rows[i].delta, rows[i].src + 1, 1'b0);
      end
      $display("test rows done");
      apb(1'b1, 8'(`EGF_RATIO_BASE + 4), 32'h7fff_ffff);
      apb(1'b0, 8'(`EGF_RATIO_BASE + 4), 32'h0);
      chkWord(rd, 32'h0013_87ff, "ratio clamp high");
      apb(1'b1, 8'(`EGF_RATIO_BASE + 4), 32'h8000_0000);
      apb(1'b0, 8'(`EGF_RATIO_BASE + 4), 32'h0);
      chkWord(rd, 32'hffec_7801, "ratio clamp");
      ratioV[1] = -1279999;
      setRatio(1, 0);
      move(4, 2, 1'b0);
      chkWord(32'(gearActive), 32'h4, "zero ratio");
      apb(1'b0, `EGF_STATUS_OFS, 32'h0);
      chkWord(rd, 32'h4, "status read");
      $display("test zero ratio done");
      // Refused writes must not disturb the register file
      apb(1'b1, `EGF_STATUS_OFS, 32'hffff_ffff);
      chkBit(err, 1'b1, "status write");
      apb(1'b0, 8'h14, 32'h0);
      chkBit(err, 1'b1, "unmapped err");
      chkWord(rd, 32'h0, "unmapped data");
      apb(1'b1, `EGF_CMD_BASE, 32'h1);
      chkBit(err, 1'b1, "cmd write");
      apb(1'b0, 8'(`EGF_CMD_BASE + 8), 32'h0);
      chkWord(rd, 32'(expPos[2]), "cmd read");
      limitIn <= 8'h04;
      repeat (8) @(posedge clk);
      gearOn[2] = 1'b0;
      chkWord(32'(gearActive), 32'h0, "limit");
      move(6, 2, 1'b0);
      limitIn <= 8'h00;
      $display("test limit done");
      apb(1'b1, `EGF_TRIPPOS_OFS, 32'(mainNow + 5));
      apb(1'b1, `EGF_TRIPCTL_OFS, 32'h31);
      @(posedge clk);
      chkBit(tripHold, 1'b1, "fwd armed");
      move(5, 1, 1'b0);
      chkBit(tripHold, 1'b1, "fwd at pos");
      move(1, 1, 1'b0);
      chkBit(tripHold, 1'b0, "fwd passed");
      apb(1'b1, `EGF_TRIPPOS_OFS, 32'(mainNow - 5));
      apb(1'b1, `EGF_TRIPCTL_OFS, 32'h33);
      move(-5, 1, 1'b0);
      chkBit(tripHold, 1'b1, "rev at pos");
      move(-1, 1, 1'b0);
      chkBit(tripHold, 1'b0, "rev passed");
      $display("test trippoints done");
      // Low enable must swallow a tick; the missed motion lands on the next one
      setRatio(2, 10000);
      ce <= 1'b0;
      move(3, 2, 1'b1);
      ce <= 1'b1;
      expPos[2] += 6;
      move(2, 2, 1'b0);
      $display("test clock enable done");
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chkWord(32'(gearActive), 32'h0, "gear after reset");
      chkWord(followCmd[2], 32'h0, "follow after reset");
      apb(1'b0, `EGF_MSEL_OFS, 32'h0);
      chkWord(rd, 32'h0, "select after reset");
      $display("test mid reset done");
      print_verdict();
   end
endmodule
